/* bench/sbr_core_props.sv */
// Port checks for the baud and register front end
`timescale 1ns/1ps
`default_nettype none
module sbr_core_props
   import sbr_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input wire logic              clk,           // Clock
   input wire logic              rst_b,         // Reset
   input wire logic              psel,          // Select
   input wire logic              penable,       // Access
   input wire logic              pwrite,        // Write
   input wire logic [ADDR_W-1:0] paddr,         // Address
   input wire logic [31:0]       pwdata,        // Write data
   input wire logic [31:0]       prdata,        // Read data
   input wire logic              pslverr,       // Error
   input wire logic              stop_mode,     // Stop
   input wire logic              rxd_in,        // Receive pin
   input wire logic              txd_out,       // Transmit level
   input wire logic              txd_oe_b,      // Transmit enable
   input wire logic              baud_tick,     // Baud pulse
   input wire logic              rx_line_idle,  // Line idle
   input wire logic              nine_bit_mode, // Nine bits
   input wire logic [3:0]        frame_bits,    // Frame length
   input wire logic              irq            // Interrupt
);
   logic       acc;
   logic [3:0] idx;
   logic       en_seen;
   assign acc = psel && penable;
   assign idx = paddr[5:2];
   // Ticks are only legal once an enable was written
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) en_seen <= 1'b0;
      else if (acc && pwrite && idx == 4'h3 && |pwdata[3:2]) en_seen <= 1'b1;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   property p_tx_level; !txd_oe_b |-> txd_out; endproperty
   a_tx_level: assert property (p_tx_level) else $error("tx not high");
   property p_tx_on; $fell(txd_oe_b) |-> $past(acc && pwrite && idx == 4'h3 && pwdata[3]); endproperty
   a_tx_on: assert property (p_tx_on) else $error("tx driven unasked");
   property p_rx_low; !rxd_in [*6] |-> !rx_line_idle; endproperty
   a_rx_low: assert property (p_rx_low) else $error("low line idle");
   property p_rsv; acc && !pwrite && idx inside {4'h6, 4'h7} |-> prdata == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved read nonzero");
   property p_unmap; acc && idx > 4'h9 |-> pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("no error");
   property p_start; baud_tick |-> en_seen; endproperty
   a_start: assert property (p_start) else $error("tick before enable");
   property p_hold; baud_tick |=> !baud_tick [*8]; endproperty
   a_hold: assert property (p_hold) else $error("period too short");
   property p_stop; stop_mode [*3] |-> !baud_tick; endproperty
   a_stop: assert property (p_stop) else $error("tick in stop");
   property p_frame; frame_bits == (nine_bit_mode ? FRAME_BITS_9 : FRAME_BITS_8); endproperty
   a_frame: assert property (p_frame) else $error("frame length");
   c_tick: cover property (baud_tick);
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule
bind sbr_core sbr_core_props #(.ADDR_W(ADDR_W)) u_props (.clk, .rst_b, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pslverr, .stop_mode, .rxd_in, .txd_out, .txd_oe_b,
   .baud_tick, .rx_line_idle, .nine_bit_mode, .frame_bits, .irq);
`default_nettype wire

/* bench/sbr_line_model.sv */
// Far-end serial line model driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module sbr_line_model (
   input  wire logic clk,     // Clock
   input  wire logic brk_req, // Pull line low
   output logic      rxd      // Receive line
);
   always_ff @(posedge clk) rxd <= !brk_req;
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the baud and register front end
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sbr_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [5:0]  paddr = 6'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic        wait_mode = 1'b0;
   logic        stop_mode = 1'b0;
   logic        brk_req = 1'b0;
   logic [31:0] prdata, rd;
   logic [3:0]  frame_bits;
   logic        pready, pslverr, rxd, txd_out, txd_oe_b, baud_tick, rx_line_idle;
   logic        nine_bit_mode, irq, err;
   int          num_errors = 0;
   int          checked = 0;
   always #20 clk = ~clk;
   sbr_core dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .wait_mode, .stop_mode, .rxd_in(rxd), .txd_out, .txd_oe_b, .baud_tick,
      .rx_line_idle, .nine_bit_mode, .frame_bits, .irq);
   sbr_line_model line_u (.clk, .brk_req, .rxd);
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // Read data stands in the access cycle and is taken at the ready edge
   task automatic apb(input logic [3:0] idx, input logic wr, input logic [31:0] d);
      int n;
      @(posedge clk);
      paddr <= {idx, 2'b00};
      pwrite <= wr;
      pwdata <= d;
      pstrb <= (idx == 4'h0) ? 4'h3 : 4'h1;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 1, 0);
      if (n >= 50) close_out();
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask
   task automatic period(input int exp);
      int n;
      n = 0;
      while (baud_tick !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (baud_tick !== 1'b1 && n < 400);
      chk("period", exp, n);
   endtask
   // Settling time lets a pending count run out first
   task automatic ticks(input int exp);
      int t;
      t = 0;
      repeat (40) @(negedge clk);
      repeat (64) begin
         @(negedge clk);
         if (baud_tick === 1'b1) t++;
      end
      chk("ticks", exp, t);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      apb(4'h6, 1'b1, 32'hFF);
      apb(4'h6, 1'b0, 32'h0);
      chk("reserved", 32'h0, rd);
      apb(4'hA, 1'b0, 32'h0);
      chk("unmapped", 1, err);
      apb(4'h0, 1'b1, 32'h1000);
      apb(4'h1, 1'b0, 32'h0);
      chk("baud_low", 32'h10, rd);
      ticks(0);
      chk("oe_idle", 1, txd_oe_b);
      chk("rx_off", 0, rx_line_idle);
      $display("test registers done");
      apb(4'h9, 1'b1, 32'h4);
      apb(4'h3, 1'b1, 32'h0C);
      period(16);
      chk("oe_on", 0, txd_oe_b);
      chk("tx_idle", 1, txd_out);
      chk("irq_set", 1, irq);
      apb(4'h8, 1'b1, 32'h4);
      chk("irq_clr", 0, irq);
      apb(4'h8, 1'b0, 32'h0);
      chk("tick_sts", 32'h1, rd & 32'h1);
      chk("rx_idle", 1, rx_line_idle);
      @(posedge clk);
      brk_req <= 1'b1;
      repeat (8) @(negedge clk);
      chk("rx_low", 0, rx_line_idle);
      @(posedge clk);
      brk_req <= 1'b0;
      apb(4'h8, 1'b0, 32'h0);
      chk("rx_edge_sts", 32'h2, rd & 32'h2);
      apb(4'h0, 1'b1, 32'h0F00);
      ticks(0);
      $display("test standard done");
      apb(4'h5, 1'b1, 32'h80);
      apb(4'h0, 1'b0, 32'h0);
      chk("alt_status", 32'h0, rd);
      apb(4'h1, 1'b1, 32'hFF);
      apb(4'h1, 1'b0, 32'h0);
      chk("alt_ctl", 32'h83, rd);
      apb(4'h2, 1'b1, 32'h80);
      apb(4'h5, 1'b1, 32'h0);
      apb(4'h5, 1'b0, 32'h0);
      chk("status_two", 32'h0, rd);
      apb(4'h0, 1'b1, 32'h2000);
      period(32);
      apb(4'h0, 1'b1, 32'h1F00);
      ticks(0);
      apb(4'h2, 1'b1, 32'h10);
      chk("frame9", 32'h1B, {nine_bit_mode, frame_bits});
      apb(4'h2, 1'b1, 32'h00);
      chk("frame8", 32'hA, {nine_bit_mode, frame_bits});
      apb(4'h0, 1'b1, 32'h2000);
      @(posedge clk);
      stop_mode <= 1'b1;
      ticks(0);
      @(posedge clk);
      stop_mode <= 1'b0;
      wait_mode <= 1'b1;
      period(32);
      ticks(2);
      apb(4'h2, 1'b1, 32'h40);
      ticks(0);
      $display("test infrared and modes done");
      close_out();
   end
endmodule
`default_nettype wire

/* core/sbr_core.sv */
// Baud generator, pin front end and banked APB register map
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RULE1] Transmit pin idles high, floats when disabled
// [RULE2] Receive line high is idle; ignored when disabled; status-one bit 1 still shows the inverted line level
// [RULE3] Reserved locations: writes ignored, reads zero
// [RULE4] Standard baud: bus clock over divisor
// [RULE5] Infrared baud: bus clock over twice upper divisor
// [RULE6] Generator stopped until first transmit/receive enable
// [RULE7] Generator held when upper divisor bits zero
// [RULE8] Offsets zero to two banked by alternate map
// [RULE9] Alternate map is status-two bit seven
// [RULE10] Software writes divisor as one word
// [RULE11] Same in all modes; wait and stop supported; the generator halts in stop, and in wait when control-one bit 6 is set
// [RULE12] Format bit selects eight or nine data bits
module sbr_core
   import sbr_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input  wire logic              clk,           // Bus clock, 25 MHz
   input  wire logic              rst_b,         // Async reset, active low
   input  wire logic              psel,          // APB select
   input  wire logic              penable,       // APB access phase
   input  wire logic              pwrite,        // APB write
   input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
   input  wire logic [31:0]       pwdata,        // APB write data
   input  wire logic [3:0]        pstrb,         // APB byte strobes
   output logic      [31:0]       prdata,        // APB read data
   output logic                   pready,        // APB ready
   output logic                   pslverr,       // APB error, unmapped
   input  wire logic              wait_mode,     // Chip in wait mode
   input  wire logic              stop_mode,     // Chip in stop mode
   input  wire logic              rxd_in,        // Receive pin
   output logic                   txd_out,       // Transmit pin level
   output logic                   txd_oe_b,      // Transmit pin enable, low drives
   output logic                   baud_tick,     // One pulse per baud period
   output logic                   rx_line_idle,  // Receive line seen high
   output logic                   nine_bit_mode, // Nine data bits selected
   output logic      [3:0]        frame_bits,    // Bits per frame
   output logic                   irq            // Level interrupt
);

   initial begin
      if (ADDR_W < 6) $error("ADDR_W must hold offset 0x24");
   end

   typedef struct packed {
      logic [15:0] divisor;
      logic [7:0]  control_one;
      logic [7:0]  alt_ctrl_one;
      logic [7:0]  alt_ctrl_two;
      logic [7:0]  control_two;
      logic [7:0]  status_two;
      logic        gen_started;
      logic [15:0] baud_cnt;
      logic [2:0]  rx_sync;
      logic        rx_level;
      logic        tick;
      logic [2:0]  irq_status;
      logic [2:0]  irq_mask;
      logic [31:0] rdata;
   } sbr_state_t;

   sbr_state_t s_reg;
   sbr_state_t s_next;

   // Word index from byte address; low bits must be zero
   function automatic logic [3:0] word_idx(input logic [ADDR_W-1:0] a);
      return a[5:2];
   endfunction

   logic        acc_wr;
   logic        acc_rd;
   logic        alt_map;
   logic        infrared;
   logic        tx_en;
   logic        rx_en;
   logic        lowpower_off;
   logic        gen_hold;
   logic [15:0] period;
   logic        mapped;
   logic [3:0]  idx;
   logic [7:0]  rbyte;
   logic        rx_edge;

   always_comb begin
      alt_map  = s_reg.status_two[POS_ALT_MAP];
      infrared = s_reg.alt_ctrl_two[POS_INFRARED];
      tx_en    = s_reg.control_two[POS_TX_ENABLE];
      rx_en    = s_reg.control_two[POS_RX_ENABLE];
      // Wait disable bit is control-one bit 6; stop halts the clocks
      lowpower_off = stop_mode | (wait_mode & s_reg.control_one[6]);
      acc_wr = psel & penable & pwrite;
      // Read captured in setup so data stands at the access edge
      acc_rd = psel & ~penable & ~pwrite;
      idx    = word_idx(paddr);
      mapped = (paddr[1:0] == 2'h0) && (idx <= IDX_IRQ_MASK);
      // [RULE7] hold on zero upper bits
      gen_hold = infrared ? (s_reg.divisor[15:HOLD_LSB_IR] == '0)
                          : (s_reg.divisor[15:HOLD_LSB_STD] == '0);
      // [RULE4] [RULE5] period selection
      period = infrared ? {s_reg.divisor[15:1], 1'b0} : s_reg.divisor;
   end

   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      // [RULE2] three-stage sampling of the pin
      s_next.rx_sync = {s_reg.rx_sync[1:0], rxd_in};
      if (s_reg.rx_sync[2] == s_reg.rx_sync[1]) begin
         s_next.rx_level = s_reg.rx_sync[1];
      end
      rx_edge = rx_en && (s_reg.rx_sync[2] == s_reg.rx_sync[1])
                && (s_reg.rx_sync[1] != s_reg.rx_level);

      // [RULE6] start latch on first enable
      if (tx_en | rx_en) begin
         s_next.gen_started = 1'b1;
      end

      // [RULE11] low-power stop of the generator
      if (!s_reg.gen_started || gen_hold || lowpower_off) begin
         s_next.baud_cnt = '0;
      end else if (s_reg.baud_cnt >= period - 16'h0001) begin
         s_next.baud_cnt = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.baud_cnt = s_reg.baud_cnt + 16'h0001;
      end

      // Events set sticky bits; set beats a same-cycle clear
      if (acc_wr && idx == IDX_IRQ_STATUS && pstrb[0]) begin
         s_next.irq_status = s_reg.irq_status & ~pwdata[2:0];
      end
      if (s_next.tick) s_next.irq_status[POS_EV_BAUD_TICK] = 1'b1;
      if (rx_edge) s_next.irq_status[POS_EV_RX_EDGE] = 1'b1;
      if ((tx_en | rx_en) && !s_reg.gen_started) begin
         s_next.irq_status[POS_EV_GEN_START] = 1'b1;
      end

      if (acc_wr) begin
         unique case (idx)
            // [RULE8] banked offsets zero to two
            {1'b0, IDX_BAUD_HIGH}: begin
               if (!alt_map) begin
                  if (pstrb[0]) s_next.divisor[15:8] = pwdata[7:0];
                  // [RULE10] word write loads both halves together
                  if (pstrb[1]) s_next.divisor[7:0] = pwdata[15:8];
               end
            end
            {1'b0, IDX_BAUD_LOW}: begin
               if (pstrb[0]) begin
                  if (alt_map) s_next.alt_ctrl_one = pwdata[7:0] & 8'h83;
                  else s_next.divisor[7:0] = pwdata[7:0];
               end
            end
            {1'b0, IDX_CONTROL_ONE}: begin
               if (pstrb[0]) begin
                  if (alt_map) s_next.alt_ctrl_two = pwdata[7:0] & 8'hE7;
                  else s_next.control_one = pwdata[7:0];
               end
            end
            {1'b0, IDX_CONTROL_TWO}: begin
               if (pstrb[0]) s_next.control_two = pwdata[7:0];
            end
            {1'b0, IDX_STATUS_TWO}: begin
               // [RULE9] alternate map bit and writable fields
               if (pstrb[0]) s_next.status_two = pwdata[7:0] & 8'h9E;
            end
            IDX_IRQ_MASK: begin
               if (pstrb[0]) s_next.irq_mask = pwdata[2:0];
            end
            // [RULE3] other locations ignore writes
            default: ;
         endcase
      end

      rbyte = 8'h00;
      unique case (idx)
         {1'b0, IDX_BAUD_HIGH}:
            rbyte = alt_map ? 8'h00 : s_reg.divisor[15:8];
         {1'b0, IDX_BAUD_LOW}:
            rbyte = alt_map ? s_reg.alt_ctrl_one : s_reg.divisor[7:0];
         {1'b0, IDX_CONTROL_ONE}:
            rbyte = alt_map ? s_reg.alt_ctrl_two : s_reg.control_one;
         {1'b0, IDX_CONTROL_TWO}: rbyte = s_reg.control_two;
         {1'b0, IDX_STATUS_ONE}:  rbyte = {6'h00, ~s_reg.rx_level, 1'b0};
         {1'b0, IDX_STATUS_TWO}:  rbyte = s_reg.status_two;
         IDX_IRQ_STATUS:          rbyte = {5'h00, s_reg.irq_status};
         IDX_IRQ_MASK:            rbyte = {5'h00, s_reg.irq_mask};
         // [RULE3] reserved reads zero
         default:                 rbyte = 8'h00;
      endcase
      if (acc_rd) begin
         s_next.rdata = {24'h000000, rbyte};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg.divisor      <= RST_DIVISOR;
         s_reg.control_one  <= RST_BYTE;
         s_reg.alt_ctrl_one <= RST_BYTE;
         s_reg.alt_ctrl_two <= RST_BYTE;
         s_reg.control_two  <= RST_BYTE;
         s_reg.status_two   <= RST_BYTE;
         s_reg.gen_started  <= 1'b0;
         s_reg.baud_cnt     <= 16'h0000;
         s_reg.rx_sync      <= 3'h7;
         s_reg.rx_level     <= 1'b1;
         s_reg.tick         <= 1'b0;
         s_reg.irq_status   <= IRQ_BITS_RST;
         s_reg.irq_mask     <= IRQ_BITS_RST;
         s_reg.rdata        <= 32'h00000000;
      end else begin
         s_reg <= s_next;
      end
   end

   // Zero-wait slave; read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = s_reg.rdata;

   // [RULE1] idle high, floating while transmitter is off
   assign txd_out  = 1'b1;
   assign txd_oe_b = ~s_reg.control_two[POS_TX_ENABLE];

   // [RULE2] disabled receiver holds rx_line_idle low; status-one bit 1 still shows the line
   assign rx_line_idle = s_reg.control_two[POS_RX_ENABLE] & s_reg.rx_level;
   assign baud_tick    = s_reg.tick;

   // [RULE12] data format select
   assign nine_bit_mode = s_reg.control_one[POS_NINE_BIT];
   assign frame_bits    = nine_bit_mode ? FRAME_BITS_9 : FRAME_BITS_8;

   assign irq = |(s_reg.irq_status & s_reg.irq_mask);

endmodule

`default_nettype wire

/* core/sbr_pkg.sv */
// Package for the serial baud generator and register front end
package sbr_pkg;
   // Register word indices (byte address is four times the index); printed offsets are byte addresses
   localparam logic [2:0] IDX_BAUD_HIGH   = 3'h0;
   localparam logic [2:0] IDX_BAUD_LOW    = 3'h1;
   localparam logic [2:0] IDX_CONTROL_ONE = 3'h2;
   localparam logic [2:0] IDX_CONTROL_TWO = 3'h3;
   localparam logic [2:0] IDX_STATUS_ONE  = 3'h4;
   localparam logic [2:0] IDX_STATUS_TWO  = 3'h5;
   localparam logic [2:0] IDX_DATA_HIGH   = 3'h6;
   localparam logic [2:0] IDX_DATA_LOW    = 3'h7;
   // Own registers: interrupt status and mask
   localparam logic [3:0] IDX_IRQ_STATUS  = 4'h8;
   localparam logic [3:0] IDX_IRQ_MASK    = 4'h9;
   // Field positions
   localparam int POS_ALT_MAP      = 7;
   localparam int POS_INFRARED     = 7;
   localparam int POS_TX_ENABLE    = 3;
   localparam int POS_RX_ENABLE    = 2;
   localparam int POS_NINE_BIT     = 4;
   localparam int POS_EV_BAUD_TICK = 0;
   localparam int POS_EV_RX_EDGE   = 1;
   localparam int POS_EV_GEN_START = 2;
   // Reset values
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [15:0] RST_DIVISOR = 16'h0000;
   localparam logic [2:0] IRQ_BITS_RST = 3'h0;
   // Baud generator hold thresholds: upper divisor bits all zero
   localparam int HOLD_LSB_STD = 4;
   localparam int HOLD_LSB_IR  = 5;
   // Frame lengths in bits including start and stop
   localparam logic [3:0] FRAME_BITS_8 = 4'hA;
   localparam logic [3:0] FRAME_BITS_9 = 4'hB;
endpackage
